// [design/mtc_regs.vh]
// Register indices, field positions, reset values and codes of the translation control block
`ifndef MTC_REGS_VH
`define MTC_REGS_VH
`define MTC_IDX_EHI 3'h0
`define MTC_IDX_ELO 3'h1
`define MTC_IDX_PTB 3'h2
`define MTC_IDX_FAR 3'h3
`define MTC_IDX_CTL 3'h4
`define MTC_IDX_ARH 3'h5
`define MTC_EHI_V 9
`define MTC_EHI_I 8
`define MTC_ELO_C 9
`define MTC_ELO_G 8
`define MTC_ELO_B 7
`define MTC_ELO_W 1
`define MTC_ELO_D 0
`define MTC_CTL_E 0
`define MTC_CTL_M 1
`define MTC_CTL_I 2
`define MTC_CTL_N 3
`define MTC_CTL_S 4
`define MTC_CTL_DLA_LO 8
`define MTC_CTL_DRP_LO 16
`define MTC_CTL_RESET 32'h00000010
`define MTC_EXC_NONE 3'h0
`define MTC_EXC_MISS 3'h1
`define MTC_EXC_PROT 3'h2
`define MTC_EXC_MOD 3'h3
`define MTC_EXC_MULTI 3'h4
`define MTC_ENTRIES 32
`define MTC_PTR_LAST 5'h1f
`endif

// [design/mtc_perm_check.v]
// Permission and dirty check of one matched entry
`timescale 1ns/1ps
`default_nettype none
module mtc_perm_check (
  input wire [2:0] permission_field,
  input wire dirty,
  input wire priv,
  input wire is_write,
  input wire is_fetch,
  output reg prot_fault,
  output reg mod_fault
);
  always @* begin
    prot_fault = 1'b0;
    // Upper bit opens the page to unprivileged code
    if (!priv && !permission_field[2]) begin
      prot_fault = 1'b1; // RULE8
    end
    if (is_write && !permission_field[1]) begin
      prot_fault = 1'b1; // RULE8
    end
    if (is_fetch && !permission_field[0]) begin
      prot_fault = 1'b1; // RULE8
    end
    // Protection takes precedence over the initial write trap
    mod_fault = is_write && !dirty && !prot_fault; // RULE10
  end
endmodule // mtc_perm_check
`default_nettype wire

// [design/mtc_seg_map.v]
// Segment decode of a virtual address
`timescale 1ns/1ps
`default_nettype none
module mtc_seg_map (
  input wire [31:0] va,
  input wire seg_en,
  input wire page_en,
  input wire priv,
  output reg seg_prot,
  output reg use_page,
  output reg [31:0] seg_pa,
  output reg seg_cached
);
  always @* begin
    seg_prot = 1'b0;
    use_page = page_en;
    seg_pa = va;
    seg_cached = 1'b1;
    if (seg_en) begin // RULE17
      seg_prot = va[31] && !priv;
      case (va[31:29])
        3'h7: begin
          use_page = 1'b0;
          seg_cached = 1'b0;
        end
        3'h5: begin
          use_page = 1'b0;
          seg_cached = 1'b0;
          seg_pa = {3'h0, va[28:0]}; // RULE23
        end
        3'h4: begin
          use_page = 1'b0;
          seg_pa = {3'h0, va[28:0]}; // RULE23
        end
        3'h6: begin
          seg_pa = {3'h0, va[28:0]};
        end
        default: begin
          seg_pa = va;
        end
      endcase
    end
  end
endmodule // mtc_seg_map
`default_nettype wire

// [design/mtc_tlb_control.v]
// Translation lookaside control: staging registers, entry store, lookup and exceptions
`include "mtc_regs.vh"
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE1: Translate 32-bit addresses, four page sizes
// RULE2: Mode bit picks private or shared lookup
// RULE3: Private hit needs identifier match unless global
// RULE4: Fault writes page number into staging high
// RULE5: Valid resets low, set on exception; invalid misses
// RULE6: Fetch flag set on exception; one TLB
// RULE7: Hardware leaves identifier and staging low alone
// RULE8: Permission codes decode to read/write/execute rights; code uses the upper bit for unprivileged access, not read
// RULE9: Size field selects compared page bits
// RULE10: Store to clean page traps initial write
// RULE11: Cacheable, bufferable, write-through attributes passed out
// RULE12: Page table base is plain storage
// RULE13: Fault address keeps latest faulting address
// RULE14: Entry write uses pointer, increments, wraps
// RULE15: Protection faults point pointer at entry
// RULE16: Lockdown amount only sets wrap value
// RULE17: Segmentation enable set after reset
// RULE18: Search sets not-found on no match
// RULE19: Invalidate bit clears all entries, reads zero
// RULE20: Enable bit turns page translation on
// RULE21: Upper accessed register absent, reads zero
// RULE22: Physical address joins frame and offset
// RULE23: Privileged cached/uncached segments clear top bits
// RULE24: Fault capture in same cycle as signal
module mtc_tlb_control (
  input wire sys_clk,
  input wire rst,
  input wire sysreg_wr,
  input wire sysreg_rd,
  input wire [2:0] sysreg_idx,
  input wire [31:0] sysreg_wdata,
  output reg [31:0] sysreg_rdata,
  input wire tlbw_req,
  input wire tlbs_req,
  input wire lookup_req,
  input wire [31:0] lookup_va,
  input wire lookup_write,
  input wire lookup_fetch,
  input wire lookup_priv,
  output reg lookup_done,
  output reg [31:0] lookup_pa,
  output reg lookup_cached,
  output reg lookup_bufferable,
  output reg lookup_write_through,
  output reg [2:0] lookup_exc
);
  reg [21:0] tlb_vpn [0:31];
  reg [7:0] tlb_space_identifier [0:31];
  reg [21:0] tlb_pfn [0:31];
  reg [9:0] tlb_attr [0:31];
  reg [31:0] tlb_valid;
  reg [21:0] ehi_vpn;
  reg ehi_valid;
  reg ehi_fetch;
  reg [7:0] ehi_space_identifier;
  reg [31:0] entry_low_staging;
  reg [31:0] page_table_base;
  reg [31:0] fault_address;
  reg ctl_e;
  reg ctl_m;
  reg ctl_n;
  reg ctl_s;
  reg [4:0] lockdown_amount;
  reg [4:0] replacement_pointer;
  reg [5:0] hit_count;
  reg [4:0] hit_idx;
  reg [5:0] srch_count;
  reg [9:0] hit_attr;
  reg [21:0] hit_mask;
  reg [31:0] page_pa;
  reg [2:0] next_exc;
  reg [31:0] next_pa;
  reg next_cached;
  reg next_buf;
  reg next_wt;
  reg [4:0] next_ptr;
  reg [31:0] rd_value;
  integer i;
  wire seg_prot;
  wire use_page;
  wire [31:0] seg_pa;
  wire seg_cached;
  wire prot_fault;
  wire mod_fault;
  wire [31:0] ctl_value;
  wire wr_ehi;
  wire wr_elo;
  wire wr_ptb;
  wire wr_far;
  wire wr_ctl;
  wire fault_take;
  wire ptr_fault;
  localparam [31:0] ctl_rst_value = `MTC_CTL_RESET;

  // Page-number mask for a size code
  function [21:0] size_mask;
    input [1:0] sz;
    begin
      case (sz)
        2'h0: size_mask = 22'h3fffff; // RULE9
        2'h1: size_mask = 22'h3ffffc; // RULE9
        2'h2: size_mask = 22'h3fffc0; // RULE9
        default: size_mask = 22'h3ffc00; // RULE9
      endcase
    end
  endfunction

  // Entry hit test shared by lookup and search
  function entry_hit;
    input valid;
    input [21:0] evpn;
    input [7:0] easid;
    input glob;
    input [1:0] sz;
    input [21:0] virtual_page_number;
    input [7:0] space_identifier;
    input shared;
    begin
      entry_hit = valid && (((evpn ^ virtual_page_number) & size_mask(sz)) == 22'h0) && // RULE5
        (shared || glob || (easid == space_identifier)); // RULE2 RULE3
    end
  endfunction

  mtc_seg_map u_seg (
    .va(lookup_va),
    .seg_en(ctl_s),
    .page_en(ctl_e),
    .priv(lookup_priv),
    .seg_prot(seg_prot),
    .use_page(use_page),
    .seg_pa(seg_pa),
    .seg_cached(seg_cached)
  );

  mtc_perm_check u_perm (
    .permission_field(hit_attr[6:4]),
    .dirty(hit_attr[`MTC_ELO_D]),
    .priv(lookup_priv),
    .is_write(lookup_write),
    .is_fetch(lookup_fetch),
    .prot_fault(prot_fault),
    .mod_fault(mod_fault)
  );

  // Single unified array serves fetch and data alike
  always @* begin
    hit_count = 6'h0;
    hit_idx = 5'h0;
    srch_count = 6'h0;
    for (i = 0; i < `MTC_ENTRIES; i = i + 1) begin
      if (entry_hit(tlb_valid[i], tlb_vpn[i], tlb_space_identifier[i], tlb_attr[i][`MTC_ELO_G],
          tlb_attr[i][3:2], lookup_va[31:10], ehi_space_identifier, ctl_m)) begin // RULE6
        hit_count = hit_count + 6'h1;
        hit_idx = i[4:0];
      end
      if (entry_hit(tlb_valid[i], tlb_vpn[i], tlb_space_identifier[i], tlb_attr[i][`MTC_ELO_G],
          tlb_attr[i][3:2], ehi_vpn, ehi_space_identifier, ctl_m)) begin
        srch_count = srch_count + 6'h1;
      end
    end
    hit_attr = tlb_attr[hit_idx];
    hit_mask = size_mask(hit_attr[3:2]);
    page_pa = {(tlb_pfn[hit_idx] & hit_mask) | (lookup_va[31:10] & ~hit_mask),
      lookup_va[9:0]}; // RULE1 RULE22
  end

  always @* begin
    next_exc = `MTC_EXC_NONE;
    next_pa = seg_pa;
    next_cached = seg_cached;
    next_buf = 1'b0;
    next_wt = 1'b0;
    if (seg_prot) begin
      next_exc = `MTC_EXC_PROT;
    end else if (use_page) begin // RULE20
      next_pa = page_pa;
      next_cached = hit_attr[`MTC_ELO_C]; // RULE11
      next_buf = hit_attr[`MTC_ELO_B]; // RULE11
      next_wt = hit_attr[`MTC_ELO_W]; // RULE11
      if (hit_count == 6'h0) begin
        next_exc = `MTC_EXC_MISS; // RULE5
      end else if (hit_count != 6'h1) begin
        next_exc = `MTC_EXC_MULTI;
      end else if (prot_fault) begin
        next_exc = `MTC_EXC_PROT;
      end else if (mod_fault) begin
        next_exc = `MTC_EXC_MOD; // RULE10
      end
    end
  end

  assign ctl_value = {11'h0, replacement_pointer, 3'h0, lockdown_amount, 3'h0,
    ctl_s, ctl_n, 1'b0, ctl_m, ctl_e}; // RULE19

  always @* begin
    case (sysreg_idx)
      `MTC_IDX_EHI: rd_value = {ehi_vpn, ehi_valid, ehi_fetch, ehi_space_identifier};
      `MTC_IDX_ELO: rd_value = entry_low_staging;
      `MTC_IDX_PTB: rd_value = page_table_base;
      `MTC_IDX_FAR: rd_value = fault_address;
      `MTC_IDX_CTL: rd_value = ctl_value;
      default: rd_value = 32'h0; // RULE21
    endcase
  end

  // Wrap reloads lockdown amount; locked entries stay writable explicitly
  always @* begin
    if (replacement_pointer == `MTC_PTR_LAST) begin
      next_ptr = lockdown_amount; // RULE14 RULE16
    end else begin
      next_ptr = replacement_pointer + 5'h1; // RULE14
    end
  end

  // Register decode for the software side
  assign wr_ehi = sysreg_wr && (sysreg_idx == `MTC_IDX_EHI);
  assign wr_elo = sysreg_wr && (sysreg_idx == `MTC_IDX_ELO);
  assign wr_ptb = sysreg_wr && (sysreg_idx == `MTC_IDX_PTB);
  assign wr_far = sysreg_wr && (sysreg_idx == `MTC_IDX_FAR);
  assign wr_ctl = sysreg_wr && (sysreg_idx == `MTC_IDX_CTL);
  assign fault_take = lookup_req && (next_exc != `MTC_EXC_NONE);
  // Only a paged protection or initial write fault moves the pointer
  assign ptr_fault = fault_take && use_page && !seg_prot &&
    ((next_exc == `MTC_EXC_PROT) || (next_exc == `MTC_EXC_MOD));

  // Hardware capture follows the software write so it wins a same-cycle clash
  always @(posedge sys_clk) begin
    if (rst) begin
      ehi_vpn <= 22'h0;
      ehi_valid <= 1'b0; // RULE5
      ehi_fetch <= 1'b0;
      ehi_space_identifier <= 8'h0;
    end else begin
      if (wr_ehi) begin
        ehi_vpn <= sysreg_wdata[31:10]; // RULE4
        ehi_valid <= sysreg_wdata[`MTC_EHI_V];
        ehi_fetch <= sysreg_wdata[`MTC_EHI_I];
        ehi_space_identifier <= sysreg_wdata[7:0]; // RULE7
      end
      if (fault_take) begin
        // Capture lands with the exception code so handlers see it at once
        ehi_vpn <= lookup_va[31:10]; // RULE4 RULE24
        ehi_valid <= 1'b1; // RULE5 RULE24
        ehi_fetch <= lookup_fetch; // RULE6 RULE24
      end
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      entry_low_staging <= 32'h0;
      page_table_base <= 32'h0;
    end else begin
      if (wr_elo) begin
        entry_low_staging <= sysreg_wdata; // RULE7
      end
      if (wr_ptb) begin
        page_table_base <= sysreg_wdata; // RULE12
      end
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      fault_address <= 32'h0;
    end else if (fault_take) begin
      fault_address <= lookup_va; // RULE13 RULE24
    end else if (wr_far) begin
      fault_address <= sysreg_wdata;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      ctl_e <= ctl_rst_value[`MTC_CTL_E];
      ctl_m <= ctl_rst_value[`MTC_CTL_M];
      ctl_n <= ctl_rst_value[`MTC_CTL_N];
      ctl_s <= ctl_rst_value[`MTC_CTL_S]; // RULE17
      lockdown_amount <= ctl_rst_value[`MTC_CTL_DLA_LO +: 5];
    end else begin
      if (wr_ctl) begin
        ctl_e <= sysreg_wdata[`MTC_CTL_E];
        ctl_m <= sysreg_wdata[`MTC_CTL_M];
        ctl_n <= sysreg_wdata[`MTC_CTL_N];
        ctl_s <= sysreg_wdata[`MTC_CTL_S];
        lockdown_amount <= sysreg_wdata[`MTC_CTL_DLA_LO +: 5];
      end
      // A search in the same cycle wins over a software write
      if (tlbs_req) begin
        ctl_n <= (srch_count == 6'h0); // RULE18
      end
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      replacement_pointer <= ctl_rst_value[`MTC_CTL_DRP_LO +: 5];
    end else begin
      if (wr_ctl) begin
        replacement_pointer <= sysreg_wdata[`MTC_CTL_DRP_LO +: 5]; // RULE14
      end
      if (tlbw_req) begin
        replacement_pointer <= next_ptr; // RULE14
      end
      if (ptr_fault) begin
        replacement_pointer <= hit_idx; // RULE15
      end
    end
  end

  // Entry fields carry no reset; the valid vector alone keeps them out of lookups
  always @(posedge sys_clk) begin
    if (rst) begin
      tlb_valid <= 32'h0;
    end else begin
      if (wr_ctl && sysreg_wdata[`MTC_CTL_I]) begin
        tlb_valid <= 32'h0; // RULE19
      end
      if (tlbw_req) begin
        tlb_vpn[replacement_pointer] <= ehi_vpn;
        tlb_space_identifier[replacement_pointer] <= ehi_space_identifier;
        tlb_pfn[replacement_pointer] <= entry_low_staging[31:10];
        tlb_attr[replacement_pointer] <= entry_low_staging[9:0];
        tlb_valid[replacement_pointer] <= ehi_valid;
      end
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      sysreg_rdata <= 32'h0;
      lookup_done <= 1'b0;
      lookup_pa <= 32'h0;
      lookup_cached <= 1'b0;
      lookup_bufferable <= 1'b0;
      lookup_write_through <= 1'b0;
      lookup_exc <= `MTC_EXC_NONE;
    end else begin
      lookup_done <= lookup_req;
      if (sysreg_rd) begin
        sysreg_rdata <= rd_value;
      end
      if (lookup_req) begin
        lookup_pa <= next_pa;
        lookup_cached <= next_cached;
        lookup_bufferable <= next_buf;
        lookup_write_through <= next_wt;
        lookup_exc <= next_exc;
      end
    end
  end
endmodule // mtc_tlb_control
`default_nettype wire

// [verification/mtc_tlb_control_checker.sv]
// Port assertions for the translation control block
`timescale 1ns/1ps
`default_nettype none
module mtc_tlb_checker (
  input wire sys_clk,
  input wire rst,
  input wire sysreg_wr,
  input wire sysreg_rd,
  input wire [2:0] sysreg_idx,
  input wire [31:0] sysreg_wdata,
  input wire [31:0] sysreg_rdata,
  input wire lookup_req,
  input wire [31:0] lookup_va,
  input wire lookup_priv,
  input wire lookup_done,
  input wire [31:0] lookup_pa,
  input wire lookup_cached,
  input wire [2:0] lookup_exc
);
  logic seg_en;
  logic pg_en;
  // Shadow of the segment and paging enables; only software writes change them
  always @(posedge sys_clk) begin
    if (rst) begin
      seg_en <= 1'b1;
      pg_en <= 1'b0;
    end else if (sysreg_wr && sysreg_idx == 3'h4) begin
      seg_en <= sysreg_wdata[4];
      pg_en <= sysreg_wdata[0];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_ptb_wr;
    sysreg_wr && sysreg_idx == 3'h2;
  endsequence
  sequence s_ptb_rd;
    sysreg_rd && sysreg_idx == 3'h2;
  endsequence
  a_done_next: assert property (lookup_req |=> lookup_done)
    else $error("lookup done missing");
  a_done_quiet: assert property (!lookup_req |=> !lookup_done)
    else $error("lookup done without request");
  a_seg_fault: assert property (lookup_req && seg_en && lookup_va[31] && !lookup_priv
    |=> lookup_exc == 3'h2) else $error("unprivileged segment access not refused");
  a_cached_seg: assert property (lookup_req && seg_en && lookup_priv &&
    lookup_va[31:29] == 3'h4 |=> lookup_pa == {3'h0, $past(lookup_va[28:0])} && lookup_cached)
    else $error("cached segment");
  a_uncached_seg: assert property (lookup_req && seg_en && lookup_priv &&
    lookup_va[31:29] == 3'h5 |=> lookup_pa == {3'h0, $past(lookup_va[28:0])} && !lookup_cached)
    else $error("uncached seg");
  a_inval_zero: assert property (sysreg_rd && sysreg_idx == 3'h4 |=> !sysreg_rdata[2])
    else $error("invalidate bit read as one");
  a_upper_zero: assert property (sysreg_rd && sysreg_idx == 3'h5 |=> sysreg_rdata == 32'h0)
    else $error("upper accessed register not zero");
  a_ptb_store: assert property (s_ptb_wr ##1 !sysreg_wr ##1 s_ptb_rd
    |=> sysreg_rdata == $past(sysreg_wdata, 3)) else $error("table base not kept");
  a_no_translation: assert property (lookup_req && !seg_en && !pg_en
    |=> lookup_pa == $past(lookup_va) && lookup_exc == 3'h0) else $error("address translated");
endmodule // mtc_tlb_checker
bind mtc_tlb_control mtc_tlb_checker u_chk (
  .sys_clk(sys_clk), .rst(rst), .sysreg_wr(sysreg_wr), .sysreg_rd(sysreg_rd),
  .sysreg_idx(sysreg_idx), .sysreg_wdata(sysreg_wdata), .sysreg_rdata(sysreg_rdata),
  .lookup_req(lookup_req), .lookup_va(lookup_va), .lookup_priv(lookup_priv),
  .lookup_done(lookup_done), .lookup_pa(lookup_pa), .lookup_cached(lookup_cached),
  .lookup_exc(lookup_exc)
);
`default_nettype wire

// [verification/mtc_pipe_model.sv]
// Pipeline side model that issues translation lookups
`timescale 1ns/1ps
`default_nettype none
module mtc_pipe_model (
  input wire sys_clk,
  output logic lookup_req,
  output logic [31:0] lookup_va,
  output logic lookup_write,
  output logic lookup_fetch,
  output logic lookup_priv
);
  initial begin
    lookup_req = 1'b0;
    lookup_va = 32'h0;
    lookup_write = 1'b0;
    lookup_fetch = 1'b0;
    lookup_priv = 1'b1;
  end
  // Qualifiers stay put after the pulse, as a stalled pipeline would keep them
  task go(input logic [31:0] va, input logic w, input logic f, input logic p);
    begin
      @(posedge sys_clk);
      #1;
      lookup_va = va;
      lookup_write = w;
      lookup_fetch = f;
      lookup_priv = p;
      lookup_req = 1'b1;
      @(posedge sys_clk);
      #1;
      lookup_req = 1'b0;
    end
  endtask
endmodule // mtc_pipe_model
`default_nettype wire

// [verification/mtc_tlb_control_test.sv]
// Self-checking bench for the translation control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin err_total++; \
  $display("wrong value %s expected %h seen %h", n, (e), (a)); end end
module mtc_tlb_control_test;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic sysreg_wr = 1'b0;
  logic sysreg_rd = 1'b0;
  logic [2:0] sysreg_idx = 3'h0;
  logic [31:0] sysreg_wdata = 32'h0;
  logic tlbw_req = 1'b0;
  logic tlbs_req = 1'b0;
  wire lookup_req, lookup_write, lookup_fetch, lookup_priv, lookup_done;
  wire lookup_cached, lookup_bufferable, lookup_write_through;
  wire [31:0] lookup_va, lookup_pa, sysreg_rdata;
  wire [2:0] lookup_exc;
  int err_total = 0;
  int n_checks = 0;
  always #20 sys_clk = ~sys_clk;
  mtc_pipe_model u_pipe (.sys_clk(sys_clk), .lookup_req(lookup_req), .lookup_va(lookup_va),
    .lookup_write(lookup_write), .lookup_fetch(lookup_fetch), .lookup_priv(lookup_priv));
  mtc_tlb_control u_dut (.sys_clk(sys_clk), .rst(rst), .sysreg_wr(sysreg_wr),
    .sysreg_rd(sysreg_rd), .sysreg_idx(sysreg_idx), .sysreg_wdata(sysreg_wdata),
    .sysreg_rdata(sysreg_rdata), .tlbw_req(tlbw_req), .tlbs_req(tlbs_req),
    .lookup_req(lookup_req), .lookup_va(lookup_va), .lookup_write(lookup_write),
    .lookup_fetch(lookup_fetch), .lookup_priv(lookup_priv), .lookup_done(lookup_done),
    .lookup_pa(lookup_pa), .lookup_cached(lookup_cached), .lookup_bufferable(lookup_bufferable),
    .lookup_write_through(lookup_write_through), .lookup_exc(lookup_exc));
  task wr(input logic [2:0] i, input logic [31:0] d);
    begin
      @(posedge sys_clk);
      #1;
      sysreg_idx = i;
      sysreg_wdata = d;
      sysreg_wr = 1'b1;
      @(posedge sys_clk);
      #1;
      sysreg_wr = 1'b0;
    end
  endtask
  task rdc(input logic [2:0] i, input logic [31:0] e, input string n);
    begin
      @(posedge sys_clk);
      #1;
      sysreg_idx = i;
      sysreg_rd = 1'b1;
      @(posedge sys_clk);
      #1;
      sysreg_rd = 1'b0;
      `CHK(n, e, sysreg_rdata)
    end
  endtask
  // One pulse of the entry write (s = 0) or the search (s = 1)
  task op(input logic s);
    begin
      @(posedge sys_clk);
      #1;
      tlbw_req = !s;
      tlbs_req = s;
      @(posedge sys_clk);
      #1;
      tlbw_req = 1'b0;
      tlbs_req = 1'b0;
    end
  endtask
  task lk(input logic [31:0] va, input logic w, f, p, input logic [2:0] ex, input logic [31:0] pa);
    begin
      u_pipe.go(va, w, f, p);
      `CHK("done", 1'b1, lookup_done)
      `CHK("exception", ex, lookup_exc)
      if (ex == 3'h0) `CHK("physical address", pa, lookup_pa)
    end
  endtask
  task t_reset;
    begin
      rdc(3'h4, 32'h10, "control");
      rdc(3'h0, 32'h0, "high staging");
      rdc(3'h5, 32'h0, "upper accessed");
      wr(3'h2, 32'hdead_beef);
      rdc(3'h2, 32'hdead_beef, "table base");
      $display("test reset done");
    end
  endtask
  task t_seg;
    begin
      lk(32'h8123_4567, 1'b0, 1'b0, 1'b1, 3'h0, 32'h0123_4567);
      `CHK("cached", 1'b1, lookup_cached)
      lk(32'ha000_0010, 1'b0, 1'b0, 1'b1, 3'h0, 32'h0000_0010);
      `CHK("uncached", 1'b0, lookup_cached)
      wr(3'h1, 32'h5a5a_5a5a);
      wr(3'h0, 32'h0000_003c);
      lk(32'he000_1c00, 1'b0, 1'b1, 1'b0, 3'h2, 32'h0);
      rdc(3'h3, 32'he000_1c00, "fault address");
      rdc(3'h0, 32'he000_1f3c, "captured high");
      rdc(3'h1, 32'h5a5a_5a5a, "low staging");
      $display("test segments done");
    end
  endtask
  task t_page;
    begin
      wr(3'h4, 32'h11);
      wr(3'h0, 32'h0040_0207);
      wr(3'h1, 32'h1234_5eb2);
      op(1'b0);
      rdc(3'h4, 32'h0001_0011, "pointer step");
      lk(32'h0040_0155, 1'b0, 1'b0, 1'b1, 3'h0, 32'h1234_5d55);
      `CHK("attributes", 3'h7, {lookup_cached, lookup_bufferable, lookup_write_through})
      lk(32'h0040_0155, 1'b1, 1'b0, 1'b1, 3'h3, 32'h0);
      rdc(3'h4, 32'h11, "hit index");
      lk(32'h0040_0155, 1'b0, 1'b0, 1'b0, 3'h2, 32'h0);
      wr(3'h0, 32'h8);
      lk(32'h0040_0155, 1'b0, 1'b0, 1'b1, 3'h1, 32'h0);
      wr(3'h4, 32'h13);
      lk(32'h0040_0155, 1'b0, 1'b0, 1'b1, 3'h0, 32'h1234_5d55);
      op(1'b1);
      rdc(3'h4, 32'h13, "found");
      wr(3'h4, 32'h15);
      lk(32'h0040_0155, 1'b0, 1'b0, 1'b1, 3'h1, 32'h0);
      op(1'b1);
      rdc(3'h4, 32'h19, "not found");
      wr(3'h4, 32'h001f_0311);
      op(1'b0);
      rdc(3'h4, 32'h0003_0311, "wrap");
      wr(3'h4, 32'h0);
      lk(32'hc000_0040, 1'b1, 1'b0, 1'b1, 3'h0, 32'hc000_0040);
      $display("test paging done");
    end
  endtask
  // 64 Kb page: offset bits 15:10 must pass untranslated, then a second copy hits twice
  task t_size;
    begin
      wr(3'h4, 32'h13);
      wr(3'h0, 32'h0005_0200);
      wr(3'h1, 32'h1230_0269);
      op(1'b0);
      lk(32'h0005_abcd, 1'b0, 1'b0, 1'b1, 3'h0, 32'h1230_abcd);
      lk(32'h0005_abcd, 1'b0, 1'b1, 1'b1, 3'h2, 32'h0);
      wr(3'h4, 32'h0001_0013);
      op(1'b0);
      lk(32'h0005_abcd, 1'b0, 1'b0, 1'b1, 3'h4, 32'h0);
      rdc(3'h0, 32'h0005_aa00, "multiple hit capture");
      $display("test page sizes done");
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    t_reset;
    t_seg;
    t_page;
    t_size;
    end_sim;
  end
  // About 100 cycles of traffic; the limit leaves a wide margin
  initial begin
    #100000;
    err_total++;
    end_sim;
  end
endmodule // mtc_tlb_control_test
`default_nettype wire
